//--- design/uart_rx_status_pkg.sv
// package: register map, field positions, reset values and sizes for the uart receive status block
package uart_rx_status_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [3:0] status_control_offset = 4'h0;
    localparam logic [3:0] rx_data_offset = 4'h4;
    localparam logic [3:0] line_control_offset = 4'h8;
    // ************************************************************
    // status/control and line control field positions
    // ************************************************************
    localparam int tx_all_empty_bit = 8;
    localparam int thr_sel_lo_bit = 6;
    localparam int addr_detect_bit = 5;
    localparam int rx_idle_bit = 4;
    localparam int parity_err_bit = 3;
    localparam int framing_err_bit = 2;
    localparam int overrun_bit = 1;
    localparam int data_avail_bit = 0;
    localparam int nine_bit_mode_bit = 0;
    // ************************************************************
    // reset values and sizes
    // ************************************************************
    localparam logic [1:0] thr_sel_reset = 2'h0;
    localparam logic addr_detect_reset = 1'b0;
    localparam logic nine_bit_reset = 1'b0;
    localparam int fifo_depth = 8;
    localparam int ptr_w = 3;
    localparam logic [3:0] thr_one = 4'h1;
    localparam logic [3:0] thr_half = 4'h4;
    localparam logic [3:0] thr_three_quarter = 4'h6;
    localparam logic [3:0] count_full = 4'h8;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage

//--- design/uart_rx_status.sv
// uart receive buffer with status/control register behind an axi4-lite slave
//
// Functional notes
// [R1] transmit-empty flag high only when shift register and buffer both empty
// [R2] threshold 00/01/10 raises receive flag at 1/4/6 buffered characters
// [R3] software never writes threshold value 11; reserved and undefined
// [R4] address detect marks ninth-bit-one characters, only in nine-bit mode
// [R5] receiver idle flag high when no character is being received
// [R6] parity error flag reflects head character of receive buffer
// [R7] framing error flag reflects head character of receive buffer
// [R8] overrun set only by hardware on overflow; cleared only by software zero
// [R9] clearing a set overrun flag empties buffer and receive shift register
// [R10] data-available flag high while buffer holds an unread character
// [R11] receive buffer is an eight-entry first-in first-out queue
// [R12] while overrun is set, new characters are dropped, stored ones kept
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module uart_rx_status
    import uart_rx_status_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_shift_empty,
    input wire logic tx_buffer_empty,
    input wire logic rx_busy,
    input wire logic rx_char_valid,
    input wire logic [8:0] rx_char_data,
    input wire logic rx_char_parity_err,
    input wire logic rx_char_framing_err,
    output logic rx_shift_clear,
    output logic rx_irq_flag,
    output logic rx_addr_char_flag
);
    // ************************************************************
    // state
    // ************************************************************
    logic [11:0] fifo_mem [fifo_depth];
    logic [ptr_w-1:0] rd_ptr_reg;
    logic [ptr_w-1:0] wr_ptr_reg;
    logic [3:0] count_reg;
    logic overrun_reg;
    logic [1:0] thr_sel_reg;
    logic addr_detect_reg;
    logic nine_bit_reg;
    logic tx_shift_s1_reg, tx_shift_s2_reg;
    logic tx_buf_s1_reg, tx_buf_s2_reg;
    logic rx_busy_s1_reg, rx_busy_s2_reg;
    logic aw_held_reg, w_held_reg;
    logic [3:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    // ************************************************************
    // decode
    // ************************************************************
    wire logic [11:0] head_entry = fifo_mem[rd_ptr_reg];
    wire logic data_avail = (count_reg != 4'h0); // [R10]
    wire logic fifo_full = (count_reg == count_full);
    wire logic aw_now = s_axi_awvalid && s_axi_awready;
    wire logic w_now = s_axi_wvalid && s_axi_wready;
    wire logic aw_have = aw_held_reg || aw_now;
    wire logic w_have = w_held_reg || w_now;
    wire logic wr_fire = aw_have && w_have && !s_axi_bvalid;
    wire logic [3:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    wire logic [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
    wire logic [3:0] wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
    wire logic wr_stat = wr_fire && (wr_addr == status_control_offset);
    wire logic wr_line = wr_fire && (wr_addr == line_control_offset);
    wire logic wr_ok = wr_stat || wr_line || (wr_fire && wr_addr == rx_data_offset);
    wire logic rd_fire = s_axi_arvalid && s_axi_arready;
    wire logic rd_data_sel = rd_fire && (s_axi_araddr == rx_data_offset);
    wire logic pop = rd_data_sel && data_avail;
    // clear only counts when the flag was set; writing zero to a clear flag is harmless
    wire logic ovr_clear = wr_stat && wr_strb[0] && !wr_data[overrun_bit] && overrun_reg; // [R9]
    // dropping while overrun keeps the stored characters for software to drain
    wire logic push_ok = rx_char_valid && !overrun_reg && !fifo_full && !ovr_clear; // [R12]
    wire logic ovr_set = rx_char_valid && !overrun_reg && fifo_full; // [R8]
    wire logic [8:0] push_data = nine_bit_reg ? rx_char_data : {1'b0, rx_char_data[7:0]};
    wire logic [3:0] count_next = count_reg + {3'h0, push_ok} - {3'h0, pop};
    wire logic [1:0] thr_next = wr_strb[0] ? wr_data[7:6] : thr_sel_reg; // [R3]
    wire logic irq_next = (thr_sel_reg == 2'h0) ? (count_next >= thr_one) :
                          (thr_sel_reg == 2'h1) ? (count_next >= thr_half) :
                          (thr_sel_reg == 2'h2) ? (count_next >= thr_three_quarter) :
                          1'b0; // [R2]
    // each pin is synchronised on its own; gating before the flops could glitch
    wire logic tx_empty_sync = tx_shift_s2_reg && tx_buf_s2_reg; // [R1]
    wire logic [31:0] status_word = {23'h0, tx_empty_sync, thr_sel_reg, addr_detect_reg,
                                     !rx_busy_s2_reg, head_entry[10] && data_avail,
                                     head_entry[11] && data_avail, overrun_reg,
                                     data_avail}; // [R1] [R5] [R6] [R7]
    wire logic [31:0] rd_word = (s_axi_araddr == status_control_offset) ? status_word :
                                (s_axi_araddr == rx_data_offset) ? {23'h0, head_entry[8:0]} :
                                (s_axi_araddr == line_control_offset) ? {31'h0, nine_bit_reg} :
                                32'h0;
    wire logic rd_known = (s_axi_araddr == status_control_offset) ||
                          (s_axi_araddr == rx_data_offset) ||
                          (s_axi_araddr == line_control_offset);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_shift_s1_reg <= 1'b1;
            tx_shift_s2_reg <= 1'b1;
            tx_buf_s1_reg <= 1'b1;
            tx_buf_s2_reg <= 1'b1;
            rx_busy_s1_reg <= 1'b0;
            rx_busy_s2_reg <= 1'b0;
        end else begin
            tx_shift_s1_reg <= tx_shift_empty; // [R1]
            tx_shift_s2_reg <= tx_shift_s1_reg;
            tx_buf_s1_reg <= tx_buffer_empty;
            tx_buf_s2_reg <= tx_buf_s1_reg;
            rx_busy_s1_reg <= rx_busy;
            rx_busy_s2_reg <= rx_busy_s1_reg; // [R5]
        end
    end

    // ************************************************************
    // receive queue
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (push_ok) begin
            // bit 9 always zero, bit 10 parity, bit 11 framing
            fifo_mem[wr_ptr_reg] <= {rx_char_framing_err, rx_char_parity_err, 1'b0, push_data};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_ptr_reg <= '0;
            wr_ptr_reg <= '0;
            count_reg <= 4'h0;
        end else if (ovr_clear) begin
            rd_ptr_reg <= '0; // [R9]
            wr_ptr_reg <= '0;
            count_reg <= 4'h0;
        end else begin
            rd_ptr_reg <= rd_ptr_reg + ptr_w'(pop); // [R11]
            wr_ptr_reg <= wr_ptr_reg + ptr_w'(push_ok);
            count_reg <= count_next;
        end
    end

    // ************************************************************
    // control and status flags
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overrun_reg <= 1'b0;
            thr_sel_reg <= thr_sel_reset;
            addr_detect_reg <= addr_detect_reset;
            nine_bit_reg <= nine_bit_reset;
            rx_irq_flag <= 1'b0;
            rx_addr_char_flag <= 1'b0;
            rx_shift_clear <= 1'b0;
        end else begin
            if (ovr_set) begin
                overrun_reg <= 1'b1; // [R8]
            end else if (ovr_clear) begin
                overrun_reg <= 1'b0;
            end
            if (wr_stat) begin
                thr_sel_reg <= thr_next;
                addr_detect_reg <= wr_strb[0] ? wr_data[addr_detect_bit] : addr_detect_reg;
            end
            if (wr_line && wr_strb[0]) begin
                nine_bit_reg <= wr_data[nine_bit_mode_bit];
            end
            rx_irq_flag <= ovr_clear ? 1'b0 : irq_next;
            rx_addr_char_flag <= push_ok && addr_detect_reg && nine_bit_reg &&
                                 rx_char_data[8]; // [R4]
            rx_shift_clear <= ovr_clear; // [R9]
        end
    end

    // ************************************************************
    // axi4-lite slave
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= resp_okay;
        end else begin
            s_axi_awready <= !aw_have && !s_axi_bvalid && !s_axi_awready;
            s_axi_wready <= !w_have && !s_axi_bvalid && !s_axi_wready;
            if (aw_now) begin
                aw_addr_reg <= s_axi_awaddr;
            end
            if (w_now) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            aw_held_reg <= wr_fire ? 1'b0 : aw_have;
            w_held_reg <= wr_fire ? 1'b0 : w_have;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? resp_okay : resp_slverr;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= resp_okay;
        end else begin
            // ready must not wait for arvalid to fall, or an early request would hang
            s_axi_arready <= !s_axi_rvalid && !rd_fire;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_known ? resp_okay : resp_slverr;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/uart_rx_status_chk.sv
// checker: bus handshake and receive-status properties at the block ports
`timescale 1ns/1ps
`default_nettype none
module uart_rx_status_chk
    import uart_rx_status_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic rx_char_valid,
    input wire logic [8:0] rx_char_data,
    input wire logic rx_shift_clear,
    input wire logic rx_irq_flag,
    input wire logic rx_addr_char_flag
);
    // *****
    // properties
    // *****
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_read_answer: assert property (ar_take |=> s_axi_rvalid) else $error("read not answered");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    a_read_unmapped: assert property (ar_take ##0 s_axi_araddr == 4'hc |=>
        s_axi_rresp == resp_slverr && s_axi_rdata == 32'h0) else $error("bad unmapped read");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during response");
    a_addr_cause: assert property (rx_addr_char_flag |-> $past(rx_char_valid) &&
        $past(rx_char_data[8])) else $error("address flag without ninth bit");
    a_clear_empty: assert property (rx_shift_clear |-> !rx_irq_flag ##1 !rx_shift_clear)
        else $error("clear left flag or pulse");
endmodule
bind uart_rx_status uart_rx_status_chk uart_rx_status_chk_i (.*);
`default_nettype wire

//--- verification/uart_rx_far_end.sv
// far-end model: a remote serial transmitter handing whole characters over
`timescale 1ns/1ps
`default_nettype none
module uart_rx_far_end (
    input wire logic aclk,
    output logic rx_busy,
    output logic rx_char_valid,
    output logic [8:0] rx_char_data,
    output logic rx_char_parity_err,
    output logic rx_char_framing_err
);
    // *****
    // character delivery
    // *****
    initial {rx_busy, rx_char_valid} = 2'h0;
    initial {rx_char_framing_err, rx_char_parity_err, rx_char_data} = 11'h0;
    // lines invert after the pulse so stale data is never mistaken for valid
    task automatic send(logic [10:0] c, int g);
        rx_busy <= 1'b1;
        repeat (g) @(posedge aclk);
        {rx_char_valid, rx_char_framing_err, rx_char_parity_err, rx_char_data} <= {1'b1, c};
        @(posedge aclk);
        {rx_busy, rx_char_valid} <= 2'h0;
        {rx_char_framing_err, rx_char_parity_err, rx_char_data} <= ~c;
    endtask
endmodule
`default_nettype wire

//--- verification/uart_rx_status_test.sv
// testbench: register map, receive buffer, thresholds and status flags
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module uart_rx_status_test import uart_rx_status_pkg::*;;
    // *****
    // signals and expectations
    // *****
    // response readies stay high, so back-to-back calls never re-raise them in one step
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
    logic s_axi_arvalid = 0, s_axi_rready = 1, tx_shift_empty = 1, tx_buffer_empty = 1;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, seed = 32'hade69291;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, thr = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic rx_busy, rx_char_valid, rx_char_parity_err, rx_char_framing_err;
    logic [8:0] rx_char_data;
    logic rx_shift_clear, rx_irq_flag, rx_addr_char_flag, ad = 0, nine = 0, ov = 0;
    logic [10:0] q[$];
    int fail_count = 0, tests_run = 0, n_addr = 0, e_addr = 0, n_clr = 0;
    uart_rx_status uart_rx_status_i (.*);
    uart_rx_far_end uart_rx_far_end_i (.*);
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) n_addr += rx_addr_char_flag;
    always @(posedge aclk) n_clr += rx_shift_clear;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] sta(logic b);
        logic h = q.size() != 0;
        return {23'h0, tx_shift_empty & tx_buffer_empty, thr, ad, ~b, h & q[0][9], h & q[0][10], ov, h};
    endfunction
    function automatic logic irq();
        return q.size() >= (thr == 0 ? 1 : thr == 1 ? 4 : 6);
    endfunction
    task automatic end_sim();
        $display("counts: %0d compared, %0d mismatched", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tmo(int n);
        if (n >= 99) begin
            fail_count++;
            end_sim();
        end
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] v);
        int n = 0;
        logic ah = 0, wh = 0;
        {s_axi_awaddr, s_axi_wdata} <= {a, v};
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        do begin
            @(posedge aclk);
            ah |= s_axi_awready & s_axi_awvalid;
            wh |= s_axi_wready & s_axi_wvalid;
            if (ah) s_axi_awvalid <= 0;
            if (wh) s_axi_wvalid <= 0;
        end while (!(ah && wh) && n++ < 99);
        do @(posedge aclk); while (!s_axi_bvalid && n++ < 99);
        r = s_axi_bresp;
        tmo(n);
    endtask
    task automatic rd(logic [3:0] a);
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(posedge aclk); while (!s_axi_arready && n++ < 99);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid && n++ < 99);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        tmo(n);
    endtask
    task automatic sc(logic b);
        rd(status_control_offset);
        `CHK(d, sta(b))
    endtask
    task automatic wctl(logic [31:0] v);
        wr(status_control_offset, v);
        `CHK(r, resp_okay)
        {thr, ad} = v[7:5];
        if (ov && !v[1]) begin
            ov = 0;
            q.delete();
        end
    endtask
    task automatic ch(logic [10:0] c, int g);
        uart_rx_far_end_i.send(c, g);
        if (!ov && q.size() < 8) begin
            q.push_back(nine ? c : c & 11'h6ff);
            e_addr += nine & ad & c[8];
        end else if (q.size() == 8) ov = 1;
        repeat (3) @(posedge aclk);
        `CHK(rx_irq_flag, irq())
    endtask
    task automatic pop();
        logic [10:0] e = q.pop_front();
        rd(rx_data_offset);
        `CHK(d, {23'h0, e[8:0]})
        @(posedge aclk);
        `CHK(rx_irq_flag, irq())
    endtask
    // *****
    // scenarios
    // *****
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        sc(0);
        rd(4'hc);
        `CHK(r, resp_slverr)
        wr(4'hc, 32'h0);
        `CHK(r, resp_slverr)
        tx_buffer_empty <= 0;
        repeat (4) @(posedge aclk);
        sc(0);
        tx_buffer_empty <= 1;
        $display("end of test: reset and map");
        // thresholds 00, 01, 10 only; the reserved code is never written
        for (int t = 0; t < 3; t++) begin
            wctl(32'(t) << 6);
            repeat (7) ch(11'(xs()), int'(xs() % 4) + 1);
            repeat (7) begin
                sc(0);
                pop();
            end
        end
        $display("end of test: thresholds");
        repeat (10) ch(11'(xs()), 1);
        sc(0);
        pop();
        ch(11'h0aa, 2);
        wctl({24'h0, thr, 6'h2});
        sc(0);
        wctl({24'h0, thr, 6'h0});
        sc(0);
        `CHK(n_clr, 1)
        $display("end of test: overrun");
        wr(line_control_offset, 32'h1);
        nine = 1;
        wctl(32'h20);
        ch(11'h1a5, 1);
        ch(11'h0a5, 1);
        wr(line_control_offset, 32'h0);
        nine = 0;
        ch(11'h1a5, 1);
        `CHK(n_addr, e_addr)
        repeat (3) pop();
        fork
            ch(11'h055, 20);
            begin
                repeat (6) @(posedge aclk);
                sc(1);
            end
        join
        pop();
        $display("end of test: address and idle");
        end_sim();
    end
endmodule
`default_nettype wire
